// ---- include/sbg_consts.vh ----
`ifndef SBG_CONSTS_VH
`define SBG_CONSTS_VH
// Register byte offsets on the AXI4-Lite slave.
`define SBG_OFF_CMD 8'h00
`define SBG_OFF_STATUS 8'h04
`define SBG_OFF_CTRL 8'h08
`define SBG_OFF_FETCH_IDX 8'h0C
`define SBG_OFF_FETCH_DATA 8'h10
`define SBG_OFF_DIR 8'h14
`define SBG_OFF_OUT 8'h18
`define SBG_OFF_PINS 8'h1C
// Command word fields.
`define SBG_CMD_OP_HI 3
`define SBG_CMD_OP_LO 0
`define SBG_CMD_PORT_HI 11
`define SBG_CMD_PORT_LO 8
`define SBG_CMD_LINE_HI 14
`define SBG_CMD_LINE_LO 12
`define SBG_CMD_VAL_HI 23
`define SBG_CMD_VAL_LO 16
// Command opcodes.
`define SBG_OP_SET_PORT_DIR 4'h1
`define SBG_OP_SET_LINE_DIR 4'h2
`define SBG_OP_WRITE_LINE 4'h3
`define SBG_OP_WRITE_PORT 4'h4
`define SBG_OP_SAMPLE_LINE 4'h5
`define SBG_OP_SAMPLE_PORT 4'h6
// Control bits.
`define SBG_CTRL_START 0
`define SBG_CTRL_CLEAR 1
// Status bits.
`define SBG_ST_RUNNING 0
`define SBG_ST_OVERFLOW 1
`define SBG_ST_IDX_LO 8
// AXI responses and reset values.
`define SBG_RESP_OKAY 2'h0
`define SBG_RESP_SLVERR 2'h2
`define SBG_BYTE_ZERO 8'h00
`define SBG_WORD_ZERO 32'h00000000
`endif

// ---- rtl/sbg_result_store.v ----
`include "sbg_consts.vh"

// Result memory that keeps one byte per read index.
module sbg_result_store #(
  parameter IDX_W = 4
) (
  input wire aclk,
  input wire wr_en,
  input wire [IDX_W-1:0] wr_idx,
  input wire [7:0] wr_data,
  input wire [IDX_W-1:0] rd_idx,
  output reg [7:0] rd_data
);
  reg [7:0] mem [0:(1<<IDX_W)-1];

  // Registered read keeps the data output from a flip-flop.
  always @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data; // RULE7
    end
    rd_data <= mem[rd_idx];
  end
endmodule // sbg_result_store

// ---- rtl/sbg_gpio_port.v ----
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`include "sbg_consts.vh"

// Operation
// RULE1 - A port-direction command makes lines with a one bit outputs and zero bits inputs.
// RULE2 - One port-direction command sets all eight lines of a port at once, bit x for line x.
// RULE3 - The host picks the port by its selector and leaves it at zero on single-port parts.
// RULE4 - A single-line read samples the chosen line of the chosen port.
// RULE5 - A single-line result is 0 for a low line and 1 for a high line.
// RULE6 - A whole-port read samples all 8 lines together as one byte.
// RULE7 - Each read gets the next index in the script and its result is kept under it.
// RULE8 - The host fetches read results only after the script has finished.
// RULE9 - A whole-port write changes only lines that are outputs.
// RULE10 - A single-line write drives the line high for 1 and low for 0.
// RULE11 - A single-line direction command changes only the selected line.
// RULE12 - After reset all lines are inputs with their output latches cleared.
module sbg_gpio_port #(
  parameter NPORTS = 1,
  parameter PORT_W = 1,
  parameter DEPTH = 16,
  parameter IDX_W = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [8*NPORTS-1:0] gpio_in,
  output wire [8*NPORTS-1:0] gpio_out,
  output wire [8*NPORTS-1:0] gpio_oe
);
  // One-hot states: idle, and the single cycle in which the read index moves on.
  localparam ST_IDLE = 2'b01;
  localparam ST_READ = 2'b10;

  // Pin-facing state: direction bitmap and output latch of every port.
  reg [8*NPORTS-1:0] dir_r;
  reg [8*NPORTS-1:0] out_r;
  // Script state and the read-index bookkeeping.
  reg [1:0] state_r;
  reg running_r;
  reg overflow_r;
  reg [IDX_W-1:0] read_idx_r;
  reg [IDX_W-1:0] fetch_idx_r;
  // Write request captured from the bus until both halves are in.
  reg aw_held_r;
  reg w_held_r;
  reg [7:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  // Result store write port, driven the cycle after a read command.
  reg res_wr;
  reg [7:0] res_data;
  wire [7:0] fetch_data;

  // Picks one byte-wide port out of a packed bus.
  function [7:0] port_byte;
    input [8*NPORTS-1:0] bus;
    input [PORT_W-1:0] sel;
    integer k;
    begin
      port_byte = `SBG_BYTE_ZERO;
      for (k = 0; k < NPORTS; k = k + 1) begin
        if (sel == k[PORT_W-1:0]) begin
          port_byte = bus[8*k +: 8];
        end
      end
    end
  endfunction

  // Flat bit position of one line inside the packed direction and latch buses.
  function integer line_index;
    input [PORT_W-1:0] sel;
    input [2:0] line;
    begin
      line_index = 8 * sel + line;
    end
  endfunction

  // True for the three registers that accept writes; anything else answers with an error.
  function wr_mapped;
    input [7:0] addr;
    begin
      wr_mapped = (addr == `SBG_OFF_CMD) || (addr == `SBG_OFF_CTRL) ||
        (addr == `SBG_OFF_FETCH_IDX);
    end
  endfunction

  sbg_result_store #(
    .IDX_W(IDX_W)
  ) u_store (
    .aclk(aclk),
    .wr_en(res_wr),
    .wr_idx(read_idx_r),
    .wr_data(res_data),
    .rd_idx(fetch_idx_r),
    .rd_data(fetch_data)
  );

  // Lines drive only while configured as outputs.
  assign gpio_out = out_r;
  assign gpio_oe = dir_r;

  // Address and data are latched separately so the master may offer them in any order.
  assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // A write is acted on once both halves are held and the previous answer is gone.
  wire wr_go = aw_held_r & w_held_r & ~s_axi_bvalid;

  // Fields of the command word held from the write data channel.
  wire [3:0] op = wdata_r[`SBG_CMD_OP_HI:`SBG_CMD_OP_LO];
  wire [PORT_W-1:0] psel = wdata_r[`SBG_CMD_PORT_LO +: PORT_W];
  wire [2:0] lsel = wdata_r[`SBG_CMD_LINE_HI:`SBG_CMD_LINE_LO];
  wire [7:0] val = wdata_r[`SBG_CMD_VAL_HI:`SBG_CMD_VAL_LO];
  wire [7:0] in_byte = port_byte(gpio_in, psel);

  // Slot that the next read command will be given.
  wire [IDX_W-1:0] read_idx_inc = read_idx_r + 1'b1;

  // Decodes of the write in hand; a command for a port that does not exist is dropped.
  wire port_ok = (wdata_r[`SBG_CMD_PORT_HI:`SBG_CMD_PORT_LO] < NPORTS);
  wire is_cmd = wr_go & (awaddr_r == `SBG_OFF_CMD) & wstrb_r[0] & port_ok;
  wire is_read = is_cmd & ((op == `SBG_OP_SAMPLE_LINE) | (op == `SBG_OP_SAMPLE_PORT));
  wire is_ctrl = wr_go & (awaddr_r == `SBG_OFF_CTRL) & wstrb_r[0];
  wire is_fidx = wr_go & (awaddr_r == `SBG_OFF_FETCH_IDX) & wstrb_r[0];

  // Write channel capture and response.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= `SBG_BYTE_ZERO;
      wdata_r <= `SBG_WORD_ZERO;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SBG_RESP_OKAY;
    end else begin
      // Address half of the write.
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr[7:0];
      end
      // Data half of the write, with its strobes.
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      // Both halves in: release them and answer; unmapped addresses get an error.
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wr_mapped(awaddr_r)) begin
          s_axi_bresp <= `SBG_RESP_OKAY;
        end else begin
          s_axi_bresp <= `SBG_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Command execution; a command is honoured only while a script is running.
  always @(posedge aclk) begin
    if (!aresetn) begin
      // Every line comes up as an input with a cleared latch.
      dir_r <= {8*NPORTS{1'b0}}; // RULE12
      out_r <= {8*NPORTS{1'b0}}; // RULE12
      read_idx_r <= {IDX_W{1'b0}};
      running_r <= 1'b0;
      overflow_r <= 1'b0;
      fetch_idx_r <= {IDX_W{1'b0}};
      res_wr <= 1'b0;
      res_data <= `SBG_BYTE_ZERO;
      state_r <= ST_IDLE;
    end else begin
      res_wr <= 1'b0;
      // Software picks which stored result the fetch register shows.
      if (is_fidx) begin
        fetch_idx_r <= wdata_r[IDX_W-1:0];
      end
      // Start opens a script at index zero and wins over finish if both are set.
      if (is_ctrl && wdata_r[`SBG_CTRL_START]) begin
        running_r <= 1'b1;
        read_idx_r <= {IDX_W{1'b0}}; // RULE7
        overflow_r <= 1'b0;
      end else if (is_ctrl && wdata_r[`SBG_CTRL_CLEAR]) begin
        running_r <= 1'b0; // RULE8
      end
      case (state_r)
        ST_IDLE: begin
          if (is_cmd && running_r) begin
            case (op)
              // The bitmap replaces the direction of all eight lines at once.
              `SBG_OP_SET_PORT_DIR: begin
                dir_r[8*psel +: 8] <= val; // RULE1 RULE2
              end
              // One line turns around; the other seven keep their direction.
              `SBG_OP_SET_LINE_DIR: begin
                dir_r[line_index(psel, lsel)] <= val[0]; // RULE11
              end
              // The latch moves even on an input line, so it shows once the line drives.
              `SBG_OP_WRITE_LINE: begin
                out_r[line_index(psel, lsel)] <= val[0]; // RULE10
              end
              // Input lines keep their latch bits; only driven lines take the new value.
              `SBG_OP_WRITE_PORT: begin
                out_r[8*psel +: 8] <= (val & dir_r[8*psel +: 8]) |
                  (out_r[8*psel +: 8] & ~dir_r[8*psel +: 8]); // RULE9
              end
              // The chosen line is stored as a plain 0 or 1.
              `SBG_OP_SAMPLE_LINE: begin
                res_data <= {7'h00, in_byte[lsel]}; // RULE4 RULE5
              end
              // All eight levels are stored as one byte, taken in the same cycle.
              `SBG_OP_SAMPLE_PORT: begin
                res_data <= in_byte; // RULE6
              end
              // Other codes are answered but do nothing.
              default: begin
              end
            endcase
            // The last slot takes one result and raises overflow; later results are
            // dropped, so a script that reads more often than the store holds loses its tail.
            if (is_read) begin
              if (read_idx_r == DEPTH - 1) begin
                overflow_r <= 1'b1;
              end
              res_wr <= ~overflow_r;
              state_r <= ST_READ;
            end
          end
        end
        ST_READ: begin
          // The index advances at the same edge that stores the result under it.
          if (!overflow_r || read_idx_r != DEPTH - 1) begin
            read_idx_r <= read_idx_inc; // RULE7
          end
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Read channel; fetch data lags the fetch index by one cycle, which the bus wait hides.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `SBG_WORD_ZERO;
      s_axi_rresp <= `SBG_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `SBG_RESP_OKAY;
      case (s_axi_araddr[7:0])
        // Status: next read index above the overflow and running flags.
        `SBG_OFF_STATUS: begin
          s_axi_rdata <= {{(24-IDX_W){1'b0}}, read_idx_r, 6'h00, overflow_r, running_r};
        end
        // Fetch index as last written.
        `SBG_OFF_FETCH_IDX: begin
          s_axi_rdata <= {{(32-IDX_W){1'b0}}, fetch_idx_r};
        end
        // Stored result at the fetch index, one cycle behind an index change.
        `SBG_OFF_FETCH_DATA: begin
          s_axi_rdata <= {24'h000000, fetch_data};
        end
        // Direction bitmap of the first port.
        `SBG_OFF_DIR: begin
          s_axi_rdata <= {24'h000000, dir_r[7:0]};
        end
        // Output latch of the first port.
        `SBG_OFF_OUT: begin
          s_axi_rdata <= {24'h000000, out_r[7:0]};
        end
        // Live levels of the first port, driven lines included.
        `SBG_OFF_PINS: begin
          s_axi_rdata <= {24'h000000, gpio_in[7:0]};
        end
        default: begin
          s_axi_rdata <= `SBG_WORD_ZERO;
          s_axi_rresp <= `SBG_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // sbg_gpio_port

// ---- tb/sbg_checker_properties.sv ----
module sbg_checker #(parameter NPORTS = 1) (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [8*NPORTS-1:0] gpio_out,
  input wire [8*NPORTS-1:0] gpio_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both halves of a write are taken at one edge.
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Pins may only move shortly after write data was offered, never on their own.
  sequence wr_recent;
    $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3);
  endsequence
  AST_RESET: assert property (disable iff (1'h0) !aresetn |=> !gpio_oe && !gpio_out)
    else $error("pins not idle after reset");
  AST_WR_ANSWER: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read response late");
  AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_R_ONCE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  // A reset clears both buses by itself, so the edge that ends it is exempt.
  AST_DIR_CAUSE: assert property ($past(aresetn) && $changed(gpio_oe) |->
    wr_recent)
    else $error("direction moved without a write");
  AST_OUT_CAUSE: assert property ($past(aresetn) && $changed(gpio_out) |->
    wr_recent)
    else $error("output latch moved without a write");
endmodule // sbg_checker

// ---- tb/sbg_pin_model.sv ----
module sbg_pin_model (
  input wire [7:0] gpio_out,
  input wire [7:0] gpio_oe,
  input wire [7:0] ext_level,
  output wire [7:0] gpio_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // A driven line shows the device latch; an input line shows the outside level.
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext_level);
endmodule // sbg_pin_model

// ---- tb/scripted_byte_gpio_port_bench.sv ----
`include "sbg_consts.vh"

module scripted_byte_gpio_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [3:0] op; logic [2:0] ln; logic [7:0] v, oe, out;} sbg_row_t;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0] gpio_in, gpio_out, gpio_oe, ext_level = 8'h5A;
  int errors = 0, checked = 0, cycles = 0;
  // Script rows: command fields, then the pin state expected after it.
  sbg_row_t rows [8] = '{
    '{`SBG_OP_SET_PORT_DIR, 3'h0, 8'hA5, 8'hA5, 8'h00},
    '{`SBG_OP_WRITE_PORT, 3'h0, 8'hFF, 8'hA5, 8'hA5},
    '{`SBG_OP_SET_LINE_DIR, 3'h1, 8'h01, 8'hA7, 8'hA5},
    '{`SBG_OP_WRITE_LINE, 3'h0, 8'h00, 8'hA7, 8'hA4},
    '{`SBG_OP_SET_LINE_DIR, 3'h7, 8'h00, 8'h27, 8'hA4},
    '{`SBG_OP_SAMPLE_LINE, 3'h4, 8'h00, 8'h27, 8'hA4},
    '{`SBG_OP_SAMPLE_LINE, 3'h1, 8'h00, 8'h27, 8'hA4},
    '{`SBG_OP_SAMPLE_PORT, 3'h0, 8'h00, 8'h27, 8'hA4}};
  logic [7:0] res [3] = '{8'h01, 8'h00, 8'h7C};

  sbg_gpio_port dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gpio_in, .gpio_out, .gpio_oe);
  sbg_pin_model pins (.gpio_out, .gpio_oe, .ext_level, .gpio_in);

  // Clock at 40 MHz.
  always #12.5 aclk = ~aclk;

  // A hang is cut short here so the run always reaches the report.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      summarize;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Address and data are offered together and each dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'h0;
    w = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready) begin
        aw = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w && s_axi_wready) begin
        w = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Run the script, fetch its results, then the refusals and a second reset.
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    chk({16'h0, gpio_oe, gpio_out}, 32'h0);
    wr(`SBG_OFF_CTRL, 32'h1);
    foreach (rows[i]) begin
      wr(`SBG_OFF_CMD, {8'h0, rows[i].v, 1'h0, rows[i].ln, 8'h0, rows[i].op});
      chk({16'h0, gpio_oe, gpio_out}, {16'h0, rows[i].oe, rows[i].out});
    end
    wr(`SBG_OFF_CTRL, 32'h2);
    wr(`SBG_OFF_CMD, {28'h0, `SBG_OP_SET_PORT_DIR});
    chk({22'h0, rsp, gpio_oe}, {22'h0, `SBG_RESP_OKAY, 8'h27});
    rdr(`SBG_OFF_STATUS);
    chk(rd & 32'hF03, 32'h300);
    rdr(`SBG_OFF_DIR);
    chk(rd, 32'h27);
    rdr(`SBG_OFF_OUT);
    chk(rd, 32'hA4);
    rdr(`SBG_OFF_PINS);
    chk(rd, 32'h7C);
    for (int i = 0; i < 3; i++) begin
      wr(`SBG_OFF_FETCH_IDX, i);
      rdr(`SBG_OFF_FETCH_DATA);
      chk(rd, {24'h0, res[i]});
    end
    rdr(8'h40);
    chk({rd[29:0], rsp}, {30'h0, `SBG_RESP_SLVERR});
    wr(8'h44, 32'hFF);
    chk({30'h0, rsp}, {30'h0, `SBG_RESP_SLVERR});
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    chk({16'h0, gpio_oe, gpio_out}, 32'h0);
    wr(`SBG_OFF_CTRL, 32'h1);
    wr(`SBG_OFF_CMD, {8'h0, 8'hFF, 4'h0, 4'h1, 4'h0, `SBG_OP_SET_PORT_DIR});
    chk({24'h0, gpio_oe}, 32'h0);
    wr(`SBG_OFF_CMD, {8'h0, 8'hFF, 12'h0, `SBG_OP_SET_PORT_DIR});
    chk({24'h0, gpio_oe}, 32'hFF);
    for (int i = 0; i <= 16; i++)
      wr(`SBG_OFF_CMD, {28'h0, `SBG_OP_SAMPLE_PORT});
    rdr(`SBG_OFF_STATUS);
    chk(rd & 32'hF03, 32'hF03);
    summarize;
  end
endmodule // scripted_byte_gpio_port_bench

bind sbg_gpio_port sbg_checker #(.NPORTS(NPORTS)) u_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .gpio_out, .gpio_oe);
